// >>> rtl/dsf_fence.sv
// Contract
// [R1] trigger control bits 31:16 give each requester's trip type, 1 secure, 0 non-secure
// [R2] trigger control bits 15:0 select which requesters may trip the fence
// [R3] fence trips on a read from a selected requester with matching security type
// [R4] affect bits 31:16 mark requesters whose write enables get replaced on trip
// [R5] affect bits 15:0 mark requesters whose read enables get replaced on trip
// [R6] on trip, marked requesters' read pairs copy from read replacement into video read enables
// [R7] on trip, marked requesters' write pairs copy from write replacement into video write enables
// [R8] blit engine is port 7 with read sources 0 and 1 and one writer
// [R9] blit enables: write bits 5:4, source 1 bits 3:2, source 0 bits 1:0
// [R10] blit bits 9:8 select trip sources, bits 11:10 give their trip types
// [R11] blit bits 14:12 make write, source 1, source 0 use bits 21:16 after trip
// [R12] parser is device port requester 9, governed by its own control register
// [R13] parser read enables in bits 1:0, write enables in bits 3:2
// [R14] parser reads trip the fence when bit 4 set and type matches bit 5
// [R15] after trip parser uses bits 11:8, bit 7 for writes, bit 6 for reads
// [R16] device read enables: odd bit secure, even bit non-secure, two bits per requester
// [R17] access without the enable for its region type is refused; all fields reset zero; non-parser device writes and other ports are always granted
// [R18] fence stays tripped with replacements in force until reset
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defs.svh"

module dsf_fence (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [11:0]       s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  input  wire dsf_pkg::dsf_req_t req,
  output dsf_pkg::dsf_resp_t     resp,
  output logic                   irq
);
  import dsf_pkg::*;

  dsf_state_t  st_ff;
  dsf_state_t  nxt_st;
  logic [31:0] rd_copy_mask;
  logic [31:0] wr_copy_mask;
  logic [5:0]  blit_eff;
  logic [3:0]  parser_eff;
  logic [1:0]  acc_en;
  logic        acc_grant;
  logic        acc_trip;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic reg_hit(input logic [9:0] idx);
    reg_hit = (idx == `DSF_IDX_TRIG)    || (idx == `DSF_IDX_AFFECT)  ||
              (idx == `DSF_IDX_RD_REPL) || (idx == `DSF_IDX_WR_REPL) ||
              (idx == `DSF_IDX_BLIT)    || (idx == `DSF_IDX_PARSER)  ||
              (idx == `DSF_IDX_DEV_RD)  || (idx == `DSF_IDX_VID_RD)  ||
              (idx == `DSF_IDX_VID_WR)  || (idx == `DSF_IDX_STATUS)  ||
              (idx == `DSF_IDX_MASK);
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    strb_merge = (old & ~m) | (d & m);
  endfunction

  // pick the secure or non-secure enable of a pair
  function automatic logic pair_allows(input logic [1:0] pair, input logic secure);
    pair_allows = secure ? pair[1] : pair[0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per requester copy masks

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_copy
      assign rd_copy_mask[2*gi +: 2] = {2{st_ff.affect[gi]}};                   // [R5]
      assign wr_copy_mask[2*gi +: 2] = {2{st_ff.affect[`DSF_AFF_WR_LSB + gi]}}; // [R4]
    end
    for (gi = 0; gi < 3; gi++) begin : g_blit
      assign blit_eff[2*gi +: 2] = (st_ff.tripped && st_ff.blit[`DSF_BLIT_REPL_SEL + gi]) ?
                                   st_ff.blit[`DSF_BLIT_REPL + 2*gi +: 2] :
                                   st_ff.blit[2*gi +: 2]; // [R11] [R9]
    end
  endgenerate

  assign parser_eff[1:0] = (st_ff.tripped && st_ff.parser[`DSF_PAR_REPL_RD_SEL]) ?
                           st_ff.parser[`DSF_PAR_REPL_RD +: 2] : st_ff.parser[`DSF_PAR_RD +: 2]; // [R15] [R13]
  assign parser_eff[3:2] = (st_ff.tripped && st_ff.parser[`DSF_PAR_REPL_WR_SEL]) ?
                           st_ff.parser[`DSF_PAR_REPL_WR +: 2] : st_ff.parser[`DSF_PAR_WR +: 2]; // [R15] [R13]

  ////////////////////////////////////////////////////////////////////////////
  // access check and trip detection

  always_comb begin
    acc_en    = 2'h0;
    acc_trip  = 1'b0;
    acc_grant = 1'b1;
    unique case (req.port)
      `DSF_PORT_VIDEO: begin
        acc_en   = req.write ? st_ff.vid_wr[2*req.idx +: 2] : st_ff.vid_rd[2*req.idx +: 2];
        acc_trip = !req.write && st_ff.trig[req.idx] &&
                   (st_ff.trig[`DSF_TRIG_TYPE_LSB + req.idx] == req.secure); // [R1] [R2] [R3]
        acc_grant = pair_allows(acc_en, req.secure); // [R17]
      end
      `DSF_PORT_BLIT: begin
        if (req.write) begin
          acc_en = blit_eff[`DSF_BLIT_WR_PAIR +: 2]; // [R8]
        end else if (req.idx < 4'h2) begin
          acc_en   = blit_eff[2*req.idx[0] +: 2]; // [R8]
          acc_trip = st_ff.blit[`DSF_BLIT_TRIG_SEL + req.idx[0]] &&
                     (st_ff.blit[`DSF_BLIT_TRIG_TYPE + req.idx[0]] == req.secure); // [R10]
        end
        acc_grant = pair_allows(acc_en, req.secure); // [R17]
      end
      `DSF_PORT_DEVICE: begin
        if (req.idx == `DSF_PARSER_IDX) begin
          acc_en    = req.write ? parser_eff[3:2] : parser_eff[1:0]; // [R12] [R13]
          acc_trip  = !req.write && st_ff.parser[`DSF_PAR_TRIG_EN] &&
                      (st_ff.parser[`DSF_PAR_TRIG_TYPE] == req.secure); // [R14]
          acc_grant = pair_allows(acc_en, req.secure); // [R17]
        end else if (!req.write) begin
          acc_en    = st_ff.dev_rd[2*req.idx +: 2]; // [R16]
          acc_grant = pair_allows(acc_en, req.secure); // [R17]
        end
      end
      default: begin
        acc_grant = 1'b1;
      end
    endcase
    acc_trip = acc_trip && req.valid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [2:0] ev;
    logic       do_write;
    logic       trip_now;
    logic       rd_status;
    ev        = 3'h0;
    do_write  = 1'b0;
    trip_now  = 1'b0;
    rd_status = 1'b0;
    nxt_st    = st_ff;

    // write channel capture, address and data in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_idx  = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata  = s_axi_wdata;
      nxt_st.wstrb  = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
      do_write       = 1'b1;
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = reg_hit(st_ff.aw_idx) ? `DSF_RESP_OKAY : `DSF_RESP_SLVERR;
    end

    if (do_write) begin
      unique case (st_ff.aw_idx)
        `DSF_IDX_TRIG:    nxt_st.trig    = strb_merge(st_ff.trig, st_ff.wdata, st_ff.wstrb);
        `DSF_IDX_AFFECT:  nxt_st.affect  = strb_merge(st_ff.affect, st_ff.wdata, st_ff.wstrb);
        `DSF_IDX_RD_REPL: nxt_st.rd_repl = strb_merge(st_ff.rd_repl, st_ff.wdata, st_ff.wstrb);
        `DSF_IDX_WR_REPL: nxt_st.wr_repl = strb_merge(st_ff.wr_repl, st_ff.wdata, st_ff.wstrb);
        `DSF_IDX_BLIT:    nxt_st.blit    = strb_merge(st_ff.blit, st_ff.wdata, st_ff.wstrb);
        `DSF_IDX_PARSER:  nxt_st.parser  = strb_merge(st_ff.parser, st_ff.wdata, st_ff.wstrb);
        `DSF_IDX_DEV_RD:  nxt_st.dev_rd  = strb_merge(st_ff.dev_rd, st_ff.wdata, st_ff.wstrb);
        `DSF_IDX_VID_RD: begin
          nxt_st.vid_rd = strb_merge(st_ff.vid_rd, st_ff.wdata, st_ff.wstrb);
          if (st_ff.tripped) begin
            nxt_st.vid_rd = (nxt_st.vid_rd & ~rd_copy_mask) | (st_ff.vid_rd & rd_copy_mask); // [R18]
          end
        end
        `DSF_IDX_VID_WR: begin
          nxt_st.vid_wr = strb_merge(st_ff.vid_wr, st_ff.wdata, st_ff.wstrb);
          if (st_ff.tripped) begin
            nxt_st.vid_wr = (nxt_st.vid_wr & ~wr_copy_mask) | (st_ff.vid_wr & wr_copy_mask); // [R18]
          end
        end
        `DSF_IDX_MASK: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.mask = st_ff.wdata[`DSF_EV_BITS-1:0];
          end
        end
        default: begin
          nxt_st.mask = nxt_st.mask;
        end
      endcase
    end

    // read channel, answer one cycle after the address is taken
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = reg_hit(s_axi_araddr[11:2]) ? `DSF_RESP_OKAY : `DSF_RESP_SLVERR;
      unique case (s_axi_araddr[11:2])
        `DSF_IDX_TRIG:    nxt_st.rdata = st_ff.trig;
        `DSF_IDX_AFFECT:  nxt_st.rdata = st_ff.affect;
        `DSF_IDX_RD_REPL: nxt_st.rdata = st_ff.rd_repl;
        `DSF_IDX_WR_REPL: nxt_st.rdata = st_ff.wr_repl;
        `DSF_IDX_BLIT:    nxt_st.rdata = st_ff.blit;
        `DSF_IDX_PARSER:  nxt_st.rdata = st_ff.parser;
        `DSF_IDX_DEV_RD:  nxt_st.rdata = st_ff.dev_rd;
        `DSF_IDX_VID_RD:  nxt_st.rdata = st_ff.vid_rd;
        `DSF_IDX_VID_WR:  nxt_st.rdata = st_ff.vid_wr;
        `DSF_IDX_STATUS: begin
          nxt_st.rdata = {29'h0000000, st_ff.status};
          rd_status    = 1'b1;
        end
        `DSF_IDX_MASK:    nxt_st.rdata = {29'h0000000, st_ff.mask};
        default:          nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_held && !nxt_st.bvalid;
    nxt_st.arready = !nxt_st.rvalid;

    // fence trip latches and copies replacements once
    trip_now = acc_trip && !st_ff.tripped;
    if (acc_trip) begin
      nxt_st.tripped = 1'b1; // [R3] [R18]
    end
    if (trip_now) begin
      nxt_st.vid_rd = (nxt_st.vid_rd & ~rd_copy_mask) | (st_ff.rd_repl & rd_copy_mask); // [R6]
      nxt_st.vid_wr = (nxt_st.vid_wr & ~wr_copy_mask) | (st_ff.wr_repl & wr_copy_mask); // [R7]
    end

    // verdict
    nxt_st.resp.valid = req.valid;
    nxt_st.resp.grant = req.valid && acc_grant; // [R17]

    // events, a set in the clearing cycle wins
    ev[`DSF_EV_TRIP]       = trip_now;
    ev[`DSF_EV_RD_REFUSED] = req.valid && !req.write && !acc_grant;
    ev[`DSF_EV_WR_REFUSED] = req.valid && req.write && !acc_grant;
    nxt_st.status = (rd_status ? 3'h0 : st_ff.status) | ev;
    nxt_st.irq    = |(nxt_st.status & nxt_st.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0; // [R17]
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready  = st_ff.wready;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign resp          = st_ff.resp;
  assign irq           = st_ff.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_trip_holds;
    @(posedge ref_clk) disable iff (rst)
    st_ff.tripped |=> st_ff.tripped [*4];
  endproperty
  a_trip_holds: assert property (p_trip_holds) else $error("fence left tripped state"); // [R18]

  property p_video_trip;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && req.port == `DSF_PORT_VIDEO && !req.write && st_ff.trig[req.idx] &&
     st_ff.trig[`DSF_TRIG_TYPE_LSB + req.idx] == req.secure) |=> st_ff.tripped;
  endproperty
  a_video_trip: assert property (p_video_trip) else $error("video read did not trip fence"); // [R3]

  property p_video_no_trip;
    @(posedge ref_clk) disable iff (rst)
    (!st_ff.tripped && req.valid && req.port == `DSF_PORT_VIDEO && !st_ff.trig[req.idx])
      |=> !st_ff.tripped;
  endproperty
  a_video_no_trip: assert property (p_video_no_trip) else $error("unselected requester tripped"); // [R2]

  property p_copy_read;
    @(posedge ref_clk) disable iff (rst)
    $rose(st_ff.tripped) |-> ((st_ff.vid_rd & $past(rd_copy_mask)) == ($past(st_ff.rd_repl) &
                                                                        $past(rd_copy_mask)));
  endproperty
  a_copy_read: assert property (p_copy_read) else $error("read replacement not copied"); // [R6]

  property p_copy_write;
    @(posedge ref_clk) disable iff (rst)
    $rose(st_ff.tripped) |-> ((st_ff.vid_wr & $past(wr_copy_mask)) == ($past(st_ff.wr_repl) &
                                                                        $past(wr_copy_mask)));
  endproperty
  a_copy_write: assert property (p_copy_write) else $error("write replacement not copied"); // [R7]

  property p_blit_write;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && req.port == `DSF_PORT_BLIT && req.write && !st_ff.tripped)
      |=> resp.valid && (resp.grant == $past(req.secure ? st_ff.blit[`DSF_BLIT_WR_PAIR + 1] :
                                                          st_ff.blit[`DSF_BLIT_WR_PAIR]));
  endproperty
  a_blit_write: assert property (p_blit_write) else $error("blit write verdict wrong"); // [R9]

  property p_parser_trip;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && req.port == `DSF_PORT_DEVICE && req.idx == `DSF_PARSER_IDX && !req.write &&
     st_ff.parser[`DSF_PAR_TRIG_EN] && st_ff.parser[`DSF_PAR_TRIG_TYPE] == req.secure)
      |=> st_ff.tripped ##1 st_ff.tripped;
  endproperty
  a_parser_trip: assert property (p_parser_trip) else $error("parser read did not trip fence"); // [R14]

  property p_parser_repl;
    @(posedge ref_clk) disable iff (rst)
    (st_ff.tripped && st_ff.parser[`DSF_PAR_REPL_RD_SEL] && req.valid && !req.write &&
     req.port == `DSF_PORT_DEVICE && req.idx == `DSF_PARSER_IDX && req.secure)
      |=> resp.grant == $past(st_ff.parser[`DSF_PAR_REPL_RD + 1]);
  endproperty
  a_parser_repl: assert property (p_parser_repl) else $error("parser replacement not used"); // [R15]

  property p_dev_read;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && !req.write && req.port == `DSF_PORT_DEVICE && req.idx != `DSF_PARSER_IDX)
      |=> resp.valid && resp.grant == $past(st_ff.dev_rd[{req.idx, req.secure}]);
  endproperty
  a_dev_read: assert property (p_dev_read) else $error("device read verdict wrong"); // [R16]

  property p_refused_irq;
    @(posedge ref_clk) disable iff (rst)
    (resp.valid && !resp.grant && st_ff.mask[`DSF_EV_RD_REFUSED] && $past(!req.write))
      |-> st_ff.irq;
  endproperty
  a_refused_irq: assert property (p_refused_irq) else $error("refused read raised no interrupt"); // [R17]

  property p_blit_src_range;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && req.port == `DSF_PORT_BLIT && !req.write && req.idx >= 4'h2)
      |=> resp.valid && !resp.grant;
  endproperty
  a_blit_src_range: assert property (p_blit_src_range) else $error("blit read of unknown source granted"); // [R8]

  property p_parser_write;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && req.port == `DSF_PORT_DEVICE && req.idx == `DSF_PARSER_IDX && req.write && !st_ff.tripped)
      |=> resp.grant == $past(req.secure ? st_ff.parser[`DSF_PAR_WR + 1] : st_ff.parser[`DSF_PAR_WR]);
  endproperty
  a_parser_write: assert property (p_parser_write) else $error("parser write verdict wrong"); // [R13]

endmodule
`default_nettype wire

// >>> rtl/dsf_defs.svh
`ifndef DSF_DEFS_SVH
`define DSF_DEFS_SVH

// register indices, byte address is four times the index
`define DSF_IDX_TRIG        10'h02e
`define DSF_IDX_AFFECT      10'h02f
`define DSF_IDX_RD_REPL     10'h030
`define DSF_IDX_WR_REPL     10'h031
`define DSF_IDX_BLIT        10'h034
`define DSF_IDX_PARSER      10'h035
`define DSF_IDX_DEV_RD      10'h036
`define DSF_IDX_VID_RD      10'h03a
`define DSF_IDX_VID_WR      10'h03b
`define DSF_IDX_STATUS      10'h03c
`define DSF_IDX_MASK        10'h03d

// reset value of every register
`define DSF_RST_REG         32'h0000_0000

// requester ports
`define DSF_PORT_VIDEO      4'h3
`define DSF_PORT_BLIT       4'h7
`define DSF_PORT_DEVICE     4'h5
`define DSF_PARSER_IDX      4'h9

// trigger control fields
`define DSF_TRIG_TYPE_LSB   16

// affect select fields
`define DSF_AFF_WR_LSB      16

// blit engine control fields
`define DSF_BLIT_TRIG_SEL   8
`define DSF_BLIT_TRIG_TYPE  10
`define DSF_BLIT_REPL_SEL   12
`define DSF_BLIT_REPL       16
`define DSF_BLIT_WR_PAIR    4

// parser control fields
`define DSF_PAR_RD          0
`define DSF_PAR_WR          2
`define DSF_PAR_TRIG_EN     4
`define DSF_PAR_TRIG_TYPE   5
`define DSF_PAR_REPL_RD_SEL 6
`define DSF_PAR_REPL_WR_SEL 7
`define DSF_PAR_REPL_RD     8
`define DSF_PAR_REPL_WR     10

// event status bits
`define DSF_EV_TRIP         0
`define DSF_EV_RD_REFUSED   1
`define DSF_EV_WR_REFUSED   2
`define DSF_EV_BITS         3

// bus answers
`define DSF_RESP_OKAY       2'h0
`define DSF_RESP_SLVERR     2'h2

`endif

// >>> rtl/dsf_pkg.sv
package dsf_pkg;

  // one access presented for a security check
  typedef struct packed {
    logic       valid;
    logic [3:0] port;
    logic [3:0] idx;
    logic       write;
    logic       secure;
  } dsf_req_t;

  // verdict, one cycle after the request
  typedef struct packed {
    logic valid;
    logic grant;
  } dsf_resp_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        arready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        aw_held;
    logic [9:0]  aw_idx;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [31:0] trig;
    logic [31:0] affect;
    logic [31:0] rd_repl;
    logic [31:0] wr_repl;
    logic [31:0] blit;
    logic [31:0] parser;
    logic [31:0] dev_rd;
    logic [31:0] vid_rd;
    logic [31:0] vid_wr;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic        irq;
    logic        tripped;
    dsf_resp_t   resp;
  } dsf_state_t;

endpackage

// >>> tb/dsf_req_model.sv
`timescale 1ns/1ps
`default_nettype none

module dsf_req_model (
  input  wire logic               ref_clk,
  output dsf_pkg::dsf_req_t       req,
  input  wire dsf_pkg::dsf_resp_t resp
);
  import dsf_pkg::*;

  initial req = '0;

  ////////////////////////////////////////////////////////////////
  // one access: stall, one cycle of valid, verdict sampled a cycle later
  task automatic access(input logic [3:0] port, input logic [3:0] idx, input logic wr,
                        input logic sec, input int unsigned gap, output dsf_resp_t got);
    dsf_req_t r;
    r.valid  = 1'b1;
    r.port   = port;
    r.idx    = idx;
    r.write  = wr;
    r.secure = sec;
    repeat (gap) @(posedge ref_clk);
    req <= r;
    @(posedge ref_clk);
    // released fields do not keep the last value
    req <= {1'b0, ~r[9:0]};
    // verdict stands until the next edge, taken as sampled there
    @(posedge ref_clk);
    got = resp;
  endtask
endmodule

`default_nettype wire

// >>> tb/ddr_secure_access_fence_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defs.svh"
`define TB_CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end

module ddr_secure_access_fence_tb;
  import dsf_pkg::*;

  localparam int TG = 0, AF = 1, RR = 2, WR = 3, BL = 4, PA = 5, DV = 6, VR = 7, VW = 8, MK = 9;
  localparam logic [9:0] REG_IDX [11] = '{`DSF_IDX_TRIG, `DSF_IDX_AFFECT, `DSF_IDX_RD_REPL, `DSF_IDX_WR_REPL,
    `DSF_IDX_BLIT, `DSF_IDX_PARSER, `DSF_IDX_DEV_RD, `DSF_IDX_VID_RD, `DSF_IDX_VID_WR, `DSF_IDX_MASK, `DSF_IDX_STATUS};
  localparam logic [31:0] CFG_MASK [10] = '{'1, '1, '1, '1, 32'h003f_7f3f, 32'h0000_0fff, '1, '1, '1, 32'h0000_0007};
  localparam logic [3:0] PORTS [4] = '{`DSF_PORT_VIDEO, `DSF_PORT_DEVICE, `DSF_PORT_BLIT, 4'h2};

  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  dsf_req_t    req;
  dsf_resp_t   resp;
  logic [31:0] cfg [10];
  logic [2:0]  st_v;
  logic        tr;
  int          num_errors = 0, num_checks = 0;

  always #2 ref_clk = ~ref_clk;

  dsf_fence dut_u (.ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .req, .resp, .irq);

  dsf_req_model model_u (.ref_clk, .req, .resp);

  ////////////////////////////////////////////////////////////////
  // register bus
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, output logic [1:0] br);
    int n = 0;
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200) num_errors++;
  endtask

  task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] rr);
    int n = 0;
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 200) num_errors++;
  endtask

  ////////////////////////////////////////////////////////////////
  // expectations
  function automatic logic [31:0] pm(input logic [15:0] sel);
    for (int k = 0; k < 16; k++)
      pm[2*k+:2] = {2{sel[k]}};
  endfunction

  function automatic logic exp_grant(input logic [3:0] p, input logic [3:0] i, input logic w, input logic s);
    logic [5:0] bl = cfg[BL][5:0];
    logic [3:0] pa = cfg[PA][3:0];
    if (tr) begin
      if (cfg[BL][14]) bl[5:4] = cfg[BL][21:20];
      if (cfg[BL][13]) bl[3:2] = cfg[BL][19:18];
      if (cfg[BL][12]) bl[1:0] = cfg[BL][17:16];
      if (cfg[PA][6]) pa[1:0] = cfg[PA][9:8];
      if (cfg[PA][7]) pa[3:2] = cfg[PA][11:10];
    end
    if (p == `DSF_PORT_BLIT) return w ? bl[4 + s] : (i < 2 && bl[2 * i + s]);
    if (p == `DSF_PORT_DEVICE) return (i == `DSF_PARSER_IDX) ? pa[{w, s}] : (w || cfg[DV][2 * i + s]);
    if (p == `DSF_PORT_VIDEO) return w ? cfg[VW][2 * i + s] : cfg[VR][2 * i + s];
    return 1'b1;
  endfunction

  function automatic logic exp_trip(input logic [3:0] p, input logic [3:0] i, input logic w, input logic s);
    if (w) return 1'b0;
    if (p == `DSF_PORT_VIDEO) return cfg[TG][i] && cfg[TG][16 + i] == s;
    if (p == `DSF_PORT_BLIT) return i < 2 && cfg[BL][8 + i] && cfg[BL][10 + i] == s;
    if (p == `DSF_PORT_DEVICE && i == `DSF_PARSER_IDX) return cfg[PA][4] && cfg[PA][5] == s;
    return 1'b0;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d, x;
    logic [1:0]  r;
    logic [3:0]  p, i;
    logic        w, s, eg;
    dsf_resp_t   got;
    void'($urandom(32'h8a39b15e));
    for (int run = 0; run < 6; run++) begin
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      tr = 1'b0;
      st_v = 3'h0;
      for (int j = 0; j < 11; j++) begin
        rd(REG_IDX[j], d, r);
        `TB_CHK(d, `DSF_RST_REG)
      end
      for (int j = 0; j < 10; j++) begin
        cfg[j] = $urandom & CFG_MASK[j];
        wr(REG_IDX[j], cfg[j], r);
        rd(REG_IDX[j], d, r);
        `TB_CHK({r, d}, {`DSF_RESP_OKAY, cfg[j]})
      end
      for (int k = 0; k < 40; k++) begin
        p = PORTS[$urandom % 4];
        i = 4'($urandom);
        w = 1'($urandom);
        s = 1'($urandom);
        if (p == `DSF_PORT_BLIT) i = {2'b00, i[1:0]};
        if (p == `DSF_PORT_DEVICE && i[3:2] == 2'b11) i = `DSF_PARSER_IDX;
        eg = exp_grant(p, i, w, s);
        model_u.access(p, i, w, s, $urandom % 3, got);
        `TB_CHK(got, {1'b1, eg})
        if (!eg) st_v[w ? 2 : 1] = 1'b1;
        if (!tr && exp_trip(p, i, w, s)) begin
          tr = 1'b1;
          st_v[0] = 1'b1;
          cfg[VR] = (cfg[VR] & ~pm(cfg[AF][15:0])) | (cfg[RR] & pm(cfg[AF][15:0]));
          cfg[VW] = (cfg[VW] & ~pm(cfg[AF][31:16])) | (cfg[WR] & pm(cfg[AF][31:16]));
        end
      end
      rd(`DSF_IDX_VID_RD, d, r);
      `TB_CHK(d, cfg[VR])
      rd(`DSF_IDX_VID_WR, d, r);
      `TB_CHK(d, cfg[VW])
      x = $urandom;
      wr(`DSF_IDX_VID_RD, x, r);
      cfg[VR] = tr ? ((x & ~pm(cfg[AF][15:0])) | (cfg[VR] & pm(cfg[AF][15:0]))) : x;
      rd(`DSF_IDX_VID_RD, d, r);
      `TB_CHK(d, cfg[VR])
      `TB_CHK(irq, |(st_v & cfg[MK][2:0]))
      wr(`DSF_IDX_STATUS, 32'hffff_ffff, r);
      rd(`DSF_IDX_STATUS, d, r);
      `TB_CHK(d, {29'h0, st_v})
      rd(`DSF_IDX_STATUS, d, r);
      `TB_CHK({irq, d}, 33'h0)
      wr(10'h032, x, r);
      `TB_CHK(r, `DSF_RESP_SLVERR)
      rd(10'h032, d, r);
      `TB_CHK({r, d}, {`DSF_RESP_SLVERR, 32'h0})
    end
    give_verdict();
  end

  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
endmodule

`default_nettype wire
